// >>> rtl/asq_ctrl.sv
// Summary of operation
// (R01) 10-bit results, four inputs plus temperature sensor
// (R02) four sequencers, depth and steps 8,4,4,1
// (R03) fifo word: result in low 10 bits
// (R04) step: input nibble plus control nibble
// (R05) sequencer runs only while enabled
// (R06) same input may repeat within sequence
// (R07) raw interrupt after each flagged step
// (R08) sequence stops after end-marked step
// (R09) circular fifo, read pops oldest entry
// (R10) status shows head, tail, full, empty
// (R11) overflow and underflow flags per sequencer
// (R12) control ticks at about 16.667 MHz
// (R13) raw status, masked status and interrupt forward
// (R14) write one clears interrupt, zero ignored
// (R15) concurrent triggers served by priority value
// (R16) software keeps priorities unique
// (R17) trigger select: processor, always, peripheral
// (R18) processor kick starts chosen sequencers
// (R19) always trigger re-requests continuously
// (R20) averaging up to 64 samples per entry
// (R21) averaging off after reset
// (R22) one averaging factor for all conversions
// (R23) priority reset gives zero highest
// (R24) software waits three clocks before access
// (R25) differential pairs 0/1 and 2/3 only
// (R26) full push dropped, empty pop flagged
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
module asq_ctrl #(
	parameter int NTRIG = 4,
	parameter int DIV = asq_pkg::CONV_DIV
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [asq_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [asq_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [asq_pkg::DATA_W-1:0] reg_rdata,
	input wire logic [NTRIG-1:0] periph_trig,
	input wire logic conv_done,
	input wire logic [asq_pkg::RES_W-1:0] conv_data,
	output logic conv_start,
	output asq_pkg::asq_conv_req_s conv_req,
	output logic [asq_pkg::NSEQ-1:0] irq
);
	localparam int N = asq_pkg::NSEQ;

	function automatic logic [2:0] pick_seq(input logic [N-1:0] pend, input logic [1:0] pri [N]);
		logic [2:0] res;
		res = 3'h0;
		for (int lvl = N - 1; lvl >= 0; lvl--) begin
			for (int s = N - 1; s >= 0; s--) begin
				if (pend[s] && pri[s] == 2'(lvl)) begin
					res = {1'b1, 2'(s)};
				end
			end
		end
		return res;
	endfunction

	function automatic logic [2:0] ptr_inc(input logic [2:0] p, input logic [3:0] depth);
		return ({1'b0, p} == depth - 4'h1) ? 3'h0 : p + 3'h1;
	endfunction

	// converter-rate tick
	logic [asq_pkg::DIV_W-1:0] div_q;
	logic tick_q;
	// (R12) divide system clock
	always_ff @(posedge clk) begin
		if (!resetn) begin
			div_q <= '0;
			tick_q <= 1'b0;
		end else if (div_q == asq_pkg::DIV_W'(DIV - 1)) begin
			div_q <= '0;
			tick_q <= 1'b1;
		end else begin
			div_q <= div_q + 1'b1;
			tick_q <= 1'b0;
		end
	end

	// register decode
	logic seq_hit;
	logic [1:0] rseq;
	assign seq_hit = reg_addr[7:6] == asq_pkg::SEQ_WIN_TAG;
	assign rseq = reg_addr[5:4];
	logic kick_wr;
	assign kick_wr = reg_wr && reg_addr == asq_pkg::OFF_KICK;

	logic [N-1:0] active_q;
	logic [N-1:0] im_q;
	logic [15:0] emux_q;
	logic [1:0] prio_q [N];
	logic [2:0] avg_q;
	logic [31:0] mux_q [N];
	logic [31:0] ctl_q [N];

	always_ff @(posedge clk) begin
		if (!resetn) begin
			active_q <= '0;
			im_q <= '0;
			emux_q <= '0;
			// (R21) averaging starts off
			avg_q <= asq_pkg::AVG_RST;
			for (int s = 0; s < N; s++) begin
				// (R23) default priority order
				prio_q[s] <= asq_pkg::PRIO_RST[4*s +: 2];
				mux_q[s] <= '0;
				ctl_q[s] <= '0;
			end
		end else if (reg_wr) begin
			if (reg_addr == asq_pkg::OFF_ACTIVE) begin
				active_q <= reg_wdata[N-1:0];
			end
			if (reg_addr == asq_pkg::OFF_IRQ_MASK) begin
				im_q <= reg_wdata[N-1:0];
			end
			if (reg_addr == asq_pkg::OFF_TRIG_SEL) begin
				emux_q <= reg_wdata[15:0];
			end
			if (reg_addr == asq_pkg::OFF_PRIO) begin
				for (int s = 0; s < N; s++) begin
					prio_q[s] <= reg_wdata[4*s +: 2];
				end
			end
			// (R20) factor capped at 64
			if (reg_addr == asq_pkg::OFF_AVG) begin
				avg_q <= (reg_wdata[2:0] > asq_pkg::AVG_MAX) ? asq_pkg::AVG_MAX : reg_wdata[2:0];
			end
			if (seq_hit && reg_addr[3:0] == asq_pkg::SUB_MUX) begin
				mux_q[rseq] <= reg_wdata;
			end
			if (seq_hit && reg_addr[3:0] == asq_pkg::SUB_CTL) begin
				ctl_q[rseq] <= reg_wdata;
			end
		end
	end

	// trigger selection per sequencer
	logic [N-1:0] trig_hit;
	always_comb begin
		logic [3:0] sel;
		sel = '0;
		for (int s = 0; s < N; s++) begin
			sel = emux_q[4*s +: 4];
			// (R19) always source re-requests
			trig_hit[s] = sel == asq_pkg::TRIG_ALWAYS;
			// (R18) processor kick
			if (kick_wr && reg_wdata[s]) begin
				trig_hit[s] = 1'b1;
			end
			// (R17) peripheral sources
			for (int t = 0; t < NTRIG; t++) begin
				if (sel == 4'(t + 1) && periph_trig[t]) begin
					trig_hit[s] = 1'b1;
				end
			end
			// (R05) disabled sequencers ignore triggers
			trig_hit[s] = trig_hit[s] && active_q[s];
		end
	end

	asq_pkg::asq_state_e state_q;
	logic [1:0] cur_q;
	logic [2:0] step_q;
	logic [asq_pkg::AVG_CNT_W-1:0] avg_cnt_q;
	logic [asq_pkg::SUM_W-1:0] sum_q;
	logic [N-1:0] pend_q;
	logic done_q;
	logic [asq_pkg::RES_W-1:0] data_q;
	logic [2:0] pick;
	logic [N-1:0] grant;
	assign pick = pick_seq(pend_q & active_q, prio_q);
	// (R15) lowest priority value wins
	always_comb begin
		grant = '0;
		if (tick_q && state_q == asq_pkg::ST_IDLE && pick[2]) begin
			grant[pick[1:0]] = 1'b1;
		end
	end

	// trigger arriving with the grant re-pends the sequencer
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pend_q <= '0;
		end else begin
			pend_q <= ((pend_q & ~grant) | trig_hit) & active_q;
		end
	end

	// (R04) current step fields
	logic [3:0] step_in;
	asq_pkg::asq_step_s step_ctl;
	logic [4:0] nib;
	logic last_step;
	logic [asq_pkg::AVG_CNT_W-1:0] avg_target;
	assign nib = {step_q, 2'b00};
	// (R06) inputs may repeat per step
	assign step_in = mux_q[cur_q][nib +: 4];
	assign step_ctl = asq_pkg::asq_step_s'(ctl_q[cur_q][nib +: 4]);
	// (R02) step count bound
	assign last_step = {1'b0, step_q} == asq_pkg::SEQ_DEPTH[cur_q] - 4'h1;
	// (R22) single factor shared by all
	assign avg_target = asq_pkg::AVG_CNT_W'(1) << avg_q;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			done_q <= 1'b0;
			data_q <= '0;
		end else if (conv_done) begin
			done_q <= 1'b1;
			data_q <= conv_data;
		end else if (tick_q && state_q == asq_pkg::ST_WAIT) begin
			done_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_q <= asq_pkg::ST_IDLE;
			cur_q <= '0;
			step_q <= '0;
			avg_cnt_q <= '0;
			sum_q <= '0;
		end else if (tick_q) begin
			unique case (state_q)
				asq_pkg::ST_IDLE: begin
					if (pick[2]) begin
						cur_q <= pick[1:0];
						step_q <= '0;
						avg_cnt_q <= '0;
						sum_q <= '0;
						state_q <= asq_pkg::ST_ISSUE;
					end
				end
				asq_pkg::ST_ISSUE: begin
					// (R05) disabling aborts the run
					state_q <= active_q[cur_q] ? asq_pkg::ST_WAIT : asq_pkg::ST_IDLE;
				end
				asq_pkg::ST_WAIT: begin
					if (done_q) begin
						// (R20) accumulate repeated samples
						sum_q <= sum_q + asq_pkg::SUM_W'(data_q);
						avg_cnt_q <= avg_cnt_q + 1'b1;
						if (avg_cnt_q + 1'b1 == avg_target) begin
							state_q <= asq_pkg::ST_STORE;
						end else begin
							state_q <= asq_pkg::ST_ISSUE;
						end
					end
				end
				asq_pkg::ST_STORE: begin
					avg_cnt_q <= '0;
					sum_q <= '0;
					// (R08) end bit halts the sequence
					if (step_ctl.last || last_step || !active_q[cur_q]) begin
						state_q <= asq_pkg::ST_IDLE;
					end else begin
						step_q <= step_q + 3'h1;
						state_q <= asq_pkg::ST_ISSUE;
					end
				end
			endcase
		end
	end

	// converter request, one pulse per sample
	always_ff @(posedge clk) begin
		if (!resetn) begin
			conv_start <= 1'b0;
			conv_req <= '0;
		end else begin
			conv_start <= tick_q && state_q == asq_pkg::ST_ISSUE && active_q[cur_q];
			if (tick_q && state_q == asq_pkg::ST_ISSUE) begin
				// (R25) pair p uses inputs 2p and 2p+1
				conv_req.pos_sel <= step_ctl.diff ? {step_in[0], 1'b0} : step_in[1:0];
				conv_req.neg_sel <= {step_in[0], 1'b1};
				conv_req.diff <= step_ctl.diff;
				// (R01) temperature sensor as source
				conv_req.temp <= step_ctl.ts;
			end
		end
	end

	// result fifos
	logic [asq_pkg::RES_W-1:0] fifo_mem [N][8];
	logic [2:0] head_q [N];
	logic [2:0] tail_q [N];
	logic [3:0] cnt_q [N];
	logic push_v;
	logic pop_v;
	logic [asq_pkg::RES_W-1:0] push_data;
	assign push_v = tick_q && state_q == asq_pkg::ST_STORE;
	// (R20) shift divides by the factor
	assign push_data = asq_pkg::RES_W'(sum_q >> avg_q);
	assign pop_v = reg_rd && seq_hit && reg_addr[3:0] == asq_pkg::SUB_FIFO;

	logic [N-1:0] push_ok;
	logic [N-1:0] pop_ok;
	logic [N-1:0] full;
	always_comb begin
		for (int s = 0; s < N; s++) begin
			full[s] = cnt_q[s] == asq_pkg::SEQ_DEPTH[s];
			// (R26) full fifo drops the result
			push_ok[s] = push_v && cur_q == 2'(s) && !full[s];
			pop_ok[s] = pop_v && rseq == 2'(s) && cnt_q[s] != 4'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			for (int s = 0; s < N; s++) begin
				head_q[s] <= '0;
				tail_q[s] <= '0;
				cnt_q[s] <= '0;
			end
		end else begin
			for (int s = 0; s < N; s++) begin
				// (R09) circular pointers
				if (push_ok[s]) begin
					head_q[s] <= ptr_inc(head_q[s], asq_pkg::SEQ_DEPTH[s]);
				end
				if (pop_ok[s]) begin
					tail_q[s] <= ptr_inc(tail_q[s], asq_pkg::SEQ_DEPTH[s]);
				end
				cnt_q[s] <= cnt_q[s] + {3'h0, push_ok[s]} - {3'h0, pop_ok[s]};
			end
		end
	end

	// storage needs no reset
	always_ff @(posedge clk) begin
		for (int s = 0; s < N; s++) begin
			if (push_ok[s]) begin
				fifo_mem[s][head_q[s]] <= push_data;
			end
		end
	end

	// sticky flags: hardware set wins over software clear
	logic [N-1:0] ris_q;
	logic [N-1:0] ovf_q;
	logic [N-1:0] unf_q;
	logic [N-1:0] irq_set;
	logic [N-1:0] ovf_set;
	logic [N-1:0] unf_set;
	always_comb begin
		for (int s = 0; s < N; s++) begin
			// (R07) flagged step raises raw bit
			irq_set[s] = push_v && cur_q == 2'(s) && step_ctl.ie;
			ovf_set[s] = push_v && cur_q == 2'(s) && full[s];
			unf_set[s] = pop_v && rseq == 2'(s) && cnt_q[s] == 4'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			ris_q <= '0;
			ovf_q <= '0;
			unf_q <= '0;
			irq <= '0;
		end else begin
			// (R14) write one to clear
			ris_q <= (ris_q & ~((reg_wr && reg_addr == asq_pkg::OFF_IRQ_CLR) ?
				reg_wdata[N-1:0] : '0)) | irq_set;
			// (R11) overflow and underflow tracking
			ovf_q <= (ovf_q & ~((reg_wr && reg_addr == asq_pkg::OFF_OVF) ?
				reg_wdata[N-1:0] : '0)) | ovf_set;
			unf_q <= (unf_q & ~((reg_wr && reg_addr == asq_pkg::OFF_UNF) ?
				reg_wdata[N-1:0] : '0)) | unf_set;
			// (R13) forwarded only when masked in
			irq <= ris_q & im_q;
		end
	end

	// read path, data in the following cycle
	logic [31:0] rd_val;
	always_comb begin
		rd_val = '0;
		if (seq_hit) begin
			unique case (reg_addr[3:0])
				asq_pkg::SUB_MUX: rd_val = mux_q[rseq];
				asq_pkg::SUB_CTL: rd_val = ctl_q[rseq];
				// (R03) result in low bits
				asq_pkg::SUB_FIFO: rd_val = {22'h0, fifo_mem[rseq][tail_q[rseq]]};
				// (R10) pointer and flag view
				asq_pkg::SUB_STAT: begin
					rd_val[asq_pkg::STAT_TAIL_LSB +: 3] = tail_q[rseq];
					rd_val[asq_pkg::STAT_HEAD_LSB +: 3] = head_q[rseq];
					rd_val[asq_pkg::STAT_EMPTY_BIT] = cnt_q[rseq] == 4'h0;
					rd_val[asq_pkg::STAT_FULL_BIT] = full[rseq];
				end
				default: rd_val = '0;
			endcase
		end else begin
			unique case (reg_addr)
				asq_pkg::OFF_ACTIVE: rd_val[N-1:0] = active_q;
				asq_pkg::OFF_RAW_IRQ: rd_val[N-1:0] = ris_q;
				asq_pkg::OFF_IRQ_MASK: rd_val[N-1:0] = im_q;
				asq_pkg::OFF_IRQ_CLR: rd_val[N-1:0] = ris_q & im_q;
				asq_pkg::OFF_OVF: rd_val[N-1:0] = ovf_q;
				asq_pkg::OFF_TRIG_SEL: rd_val[15:0] = emux_q;
				asq_pkg::OFF_UNF: rd_val[N-1:0] = unf_q;
				asq_pkg::OFF_AVG: rd_val[2:0] = avg_q;
				asq_pkg::OFF_PRIO: begin
					for (int s = 0; s < N; s++) begin
						rd_val[4*s +: 2] = prio_q[s];
					end
				end
				default: rd_val = '0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			reg_rdata <= rd_val;
		end else begin
			reg_rdata <= '0;
		end
	end

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	logic [asq_pkg::RES_W-1:0] oldest;
	assign oldest = fifo_mem[rseq][tail_q[rseq]];

	// independent count of cycles between ticks
	logic [asq_pkg::DIV_W-1:0] gap_q;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			gap_q <= '0;
		end else begin
			gap_q <= tick_q ? asq_pkg::DIV_W'(1) : gap_q + 1'b1;
		end
	end

	// any pending sequencer ranked above the winner
	logic prio_beaten;
	always_comb begin
		prio_beaten = 1'b0;
		for (int s = 0; s < N; s++) begin
			if (pend_q[s] && active_q[s] && prio_q[s] < prio_q[pick[1:0]]) begin
				prio_beaten = 1'b1;
			end
		end
	end

	property p_tick_spacing;
		tick_q |-> gap_q == asq_pkg::DIV_W'(DIV);
	endproperty
	a_tick_spacing: assert property (p_tick_spacing) else $error("tick came too soon"); // R12

	property p_pop_oldest;
		|pop_ok |=> reg_rdata == {22'h0, $past(oldest)};
	endproperty
	a_pop_oldest: assert property (p_pop_oldest) else $error("pop did not return oldest"); // R09

	property p_ovf_set;
		|ovf_set |=> (ovf_q & $past(ovf_set)) == $past(ovf_set);
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("overflow flag missed"); // R26

	property p_unf_set;
		pop_v && cnt_q[rseq] == 4'h0 |=> unf_q[$past(rseq)];
	endproperty
	a_unf_set: assert property (p_unf_set) else $error("underflow flag missed"); // R11

	property p_clear_one;
		reg_wr && reg_addr == asq_pkg::OFF_IRQ_CLR && reg_wdata[0] && !irq_set[0] |=> !ris_q[0];
	endproperty
	a_clear_one: assert property (p_clear_one) else $error("interrupt not cleared"); // R14

	property p_clear_zero;
		reg_wr && reg_addr == asq_pkg::OFF_IRQ_CLR && !reg_wdata[3] && ris_q[3] |=> ris_q[3];
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("zero write cleared bit"); // R14

	property p_irq_masked;
		!im_q[0] |=> ##1 !irq[0] || $past(im_q[0]);
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("masked interrupt forwarded"); // R13

	property p_end_stops;
		push_v && step_ctl.last |=> state_q == asq_pkg::ST_IDLE;
	endproperty
	a_end_stops: assert property (p_end_stops) else $error("sequence ran past end"); // R08

	property p_grant_prio;
		|grant |-> !prio_beaten && (grant & pend_q & active_q) == grant;
	endproperty
	a_grant_prio: assert property (p_grant_prio) else $error("priority order broken"); // R15

	property p_step_irq;
		|irq_set |=> (ris_q & $past(irq_set)) == $past(irq_set);
	endproperty
	a_step_irq: assert property (p_step_irq) else $error("step interrupt missed"); // R07

	c_full_seq0: cover property (full[0] && push_v && cur_q == 2'h0);
	c_avg_store: cover property (avg_q != 3'h0 && push_v);
	c_diff_req: cover property (conv_start && conv_req.diff);
	c_irq_out: cover property (|irq);
endmodule

// >>> shared/asq_pkg.sv
package asq_pkg;
	localparam int NSEQ = 4;
	localparam int RES_W = 10;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int SUM_W = 16;
	localparam int PTR_W = 3;
	localparam int CNT_W = 4;
	localparam int AVG_CNT_W = 7;
	localparam int DIV_W = 5;

	// global register offsets
	localparam logic [7:0] OFF_ACTIVE = 8'h00;
	localparam logic [7:0] OFF_RAW_IRQ = 8'h04;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h08;
	localparam logic [7:0] OFF_IRQ_CLR = 8'h0c;
	localparam logic [7:0] OFF_OVF = 8'h10;
	localparam logic [7:0] OFF_TRIG_SEL = 8'h14;
	localparam logic [7:0] OFF_UNF = 8'h18;
	localparam logic [7:0] OFF_PRIO = 8'h20;
	localparam logic [7:0] OFF_KICK = 8'h28;
	localparam logic [7:0] OFF_AVG = 8'h30;
	// per-sequencer window: 0x80 + 0x10 * n, sub-offsets below
	localparam logic [1:0] SEQ_WIN_TAG = 2'h2;
	localparam logic [3:0] SUB_MUX = 4'h0;
	localparam logic [3:0] SUB_CTL = 4'h4;
	localparam logic [3:0] SUB_FIFO = 4'h8;
	localparam logic [3:0] SUB_STAT = 4'hc;

	localparam logic [31:0] PRIO_RST = 32'h0000_3210;
	localparam logic [2:0] AVG_RST = 3'h0;
	localparam logic [2:0] AVG_MAX = 3'h6;
	localparam logic [3:0] TRIG_PROC = 4'h0;
	localparam logic [3:0] TRIG_ALWAYS = 4'hf;
	localparam logic [3:0] SEQ_DEPTH [0:3] = '{4'h8, 4'h4, 4'h4, 4'h1};

	// status word field positions
	localparam int STAT_TAIL_LSB = 0;
	localparam int STAT_HEAD_LSB = 4;
	localparam int STAT_EMPTY_BIT = 8;
	localparam int STAT_FULL_BIT = 12;

	localparam int SYS_CLK_KHZ = 250000;
	localparam int CONV_CLK_KHZ = 16667;
	localparam int CONV_DIV = (SYS_CLK_KHZ + CONV_CLK_KHZ / 2) / CONV_CLK_KHZ;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ISSUE = 2'b01,
		ST_WAIT = 2'b10,
		ST_STORE = 2'b11
	} asq_state_e;

	typedef struct packed {
		logic ts;
		logic ie;
		logic last;
		logic diff;
	} asq_step_s;

	typedef struct packed {
		logic [1:0] pos_sel;
		logic [1:0] neg_sel;
		logic diff;
		logic temp;
	} asq_conv_req_s;
endpackage

// >>> test/asq_conv_model.sv
`timescale 1ns/1ps
module asq_conv_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic conv_start,
	input wire asq_pkg::asq_conv_req_s conv_req,
	input wire logic [3:0] delay,
	output logic conv_done,
	output logic [asq_pkg::RES_W-1:0] conv_data
);
	logic busy;
	logic [3:0] cnt;
	logic [asq_pkg::RES_W-1:0] val;

	always_ff @(posedge clk) begin
		conv_done <= 1'b0;
		if (!resetn) begin
			busy <= 1'b0;
			cnt <= 4'h0;
			conv_data <= 10'h155;
		end else if (conv_start) begin
			busy <= 1'b1;
			cnt <= delay;
			val <= conv_req.temp ? 10'h2aa :
				{4'ha, 1'b0, conv_req.diff, conv_req.pos_sel,
				conv_req.diff ? conv_req.neg_sel : 2'h0};
		end else if (busy && cnt == 4'h0) begin
			busy <= 1'b0;
			conv_done <= 1'b1;
			conv_data <= val;
		end else begin
			if (busy) begin
				cnt <= cnt - 4'h1;
			end
			// data is not held outside the done and start cycles
			conv_data <= ~conv_data;
		end
	end
endmodule

// >>> test/tb.sv
`timescale 1ns/1ps
module tb;
	logic clk;
	logic resetn;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	logic [3:0] periph_trig;
	logic conv_done;
	logic [9:0] conv_data;
	logic conv_start;
	asq_pkg::asq_conv_req_s conv_req;
	logic [3:0] irq;
	logic [3:0] delay;
	int n_fail = 0;
	int samples_checked = 0;
	int n_conv = 0;
	int base;
	logic [31:0] d;
	asq_pkg::asq_conv_req_s reqs [$];
	logic [7:0] offs [11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
		8'h18, 8'h20, 8'h28, 8'h30, 8'h40};
	logic [1:0] seq0_in [5] = '{2'h1, 2'h1, 2'h3, 2'h0, 2'h1};

	asq_ctrl #(.NTRIG(4), .DIV(2)) dut_u (
		.clk(clk),
		.resetn(resetn),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.periph_trig(periph_trig),
		.conv_done(conv_done),
		.conv_data(conv_data),
		.conv_start(conv_start),
		.conv_req(conv_req),
		.irq(irq)
	);

	asq_conv_model conv_u (
		.clk(clk),
		.resetn(resetn),
		.conv_start(conv_start),
		.conv_req(conv_req),
		.delay(delay),
		.conv_done(conv_done),
		.conv_data(conv_data)
	);

	always #2 clk = ~clk;

	always @(posedge clk) begin
		if (conv_start === 1'b1) begin
			n_conv++;
			reqs.push_back(conv_req);
		end
	end

	function automatic logic [31:0] ex(input logic t, input logic df,
		input logic [1:0] p, input logic [1:0] n);
		return t ? 32'h0000_02aa : {22'h0, 4'ha, 1'b0, df, p, df ? n : 2'h0};
	endfunction

	task automatic summarize;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string nm);
		logic [31:0] v;
		rd(a, v);
		chk(nm, v, exp);
	endtask

	task automatic wait_bit(input logic [7:0] a, input int b);
		logic [31:0] v;
		for (int i = 0; i < 300; i++) begin
			rd(a, v);
			if (v[b] === 1'b1) begin
				return;
			end
		end
		n_fail++;
		summarize();
	endtask

	task automatic wait_conv(input int n);
		for (int i = 0; i < 2000; i++) begin
			@(posedge clk);
			if (n_conv >= n) begin
				return;
			end
		end
		n_fail++;
		summarize();
	endtask

	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		periph_trig = 4'h0;
		delay = 4'h1;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk); // settle before access
		for (int i = 0; i < 11; i++) begin
			rc(offs[i], (offs[i] == 8'h20) ? asq_pkg::PRIO_RST : 32'h0, "reset");
		end
		chk("irq_rst", {28'h0, irq}, 32'h0); // idle
		// single step on sequencer three, interrupt masked in
		wr(8'hb0, 32'h2);
		wr(8'hb4, 32'h6);
		wr(8'h08, 32'h8);
		wr(8'h00, 32'h8);
		wr(8'h28, 32'h8);
		wait_bit(8'h04, 3);
		chk("irq3", {28'h0, irq}, 32'h8); // forwarded
		rc(8'h0c, 32'h8, "masked"); // masked view
		wr(8'h0c, 32'h0);
		rc(8'h0c, 32'h8, "clr_zero"); // zero ignored
		wr(8'h0c, 32'h8);
		rc(8'h04, 32'h0, "clr_one"); // one clears
		chk("irq3_off", {28'h0, irq}, 32'h0); // line drops
		// second result into the full one-deep queue
		base = n_conv;
		wr(8'h28, 32'h8);
		wait_bit(8'h10, 3);
		chk("one_conv", n_conv, base + 1); // one step
		rd(8'hbc, d);
		chk("full3", d[12], 1'b1); // full flag
		rc(8'hb8, ex(1'b0, 1'b0, 2'h2, 2'h0), "pop3");
		rd(8'hbc, d);
		chk("empty3", d[8], 1'b1); // empty flag
		rd(8'hb8, d);
		rc(8'h18, 32'h8, "unf"); // underflow
		wr(8'h18, 32'h8);
		wr(8'h10, 32'h8);
		wr(8'h0c, 32'h8);
		rc(8'h18, 32'h0, "unf_clr"); // flag clears
		rc(8'h10, 32'h0, "ovf_clr"); // flag clears
		// sequencer zero: end marked at fifth step, inputs repeat
		wr(8'h80, 32'h2221_0311);
		wr(8'h84, 32'h2002_0040);
		wr(8'h00, 32'h1);
		base = n_conv;
		wr(8'h28, 32'h1);
		wait_conv(base + 5);
		repeat (100) @(posedge clk);
		chk("steps", n_conv, base + 5); // stops after end
		rc(8'h8c, 32'h0000_0050, "stat0"); // pointers
		rd(8'h04, d);
		chk("raw0", d[0], 1'b1); // flagged step
		chk("irq0", irq[0], 1'b0); // mask off
		for (int i = 0; i < 5; i++) begin
			rc(8'h88, ex(1'b0, 1'b0, seq0_in[i], 2'h0), "pop0"); // oldest
		end
		rc(8'h8c, 32'h0000_0155, "stat0_e"); // tail at head, empty
		wr(8'h0c, 32'h1);
		// simultaneous peripheral triggers, sequencer two ranked first
		wr(8'h20, 32'h0000_3012); // distinct priorities
		wr(8'h14, 32'h0000_0210);
		wr(8'h90, 32'h0);
		wr(8'h94, 32'h2);
		wr(8'ha0, 32'h3);
		wr(8'ha4, 32'h2);
		wr(8'h00, 32'h6);
		reqs.delete();
		base = n_conv;
		@(posedge clk);
		periph_trig <= 4'h3;
		@(posedge clk);
		periph_trig <= 4'h0;
		wait_conv(base + 2);
		chk("first", reqs[0].pos_sel, 2'h3); // priority order
		chk("second", reqs[1].pos_sel, 2'h0); // priority order
		repeat (60) @(posedge clk);
		rc(8'h98, ex(1'b0, 1'b0, 2'h0, 2'h0), "pop1"); // peripheral
		rc(8'ha8, ex(1'b0, 1'b0, 2'h3, 2'h0), "pop2"); // peripheral
		// differential pair one, then temperature sensor
		wr(8'h90, 32'h1);
		wr(8'h94, 32'h0000_00a1);
		wr(8'h00, 32'h2);
		reqs.delete();
		base = n_conv;
		wr(8'h28, 32'h2);
		wait_conv(base + 2);
		chk("pair", reqs[0], 6'b10_11_1_0); // inputs two and three
		chk("temp", reqs[1].temp, 1'b1); // sensor
		repeat (60) @(posedge clk);
		rc(8'h98, ex(1'b0, 1'b1, 2'h2, 2'h3), "diff");
		rc(8'h98, ex(1'b1, 1'b0, 2'h0, 2'h0), "tsens");
		// averaging, with a slow converter
		wr(8'h30, 32'h7);
		rc(8'h30, 32'h6, "avg_cap"); // sixty-four max
		wr(8'h30, 32'h2);
		delay = 4'h7;
		wr(8'h00, 32'h8);
		base = n_conv;
		wr(8'h28, 32'h8);
		wait_bit(8'h04, 3);
		chk("avg_n", n_conv, base + 4); // four samples
		rc(8'hb8, ex(1'b0, 1'b0, 2'h2, 2'h0), "avg_val");
		// disabled sequencer ignores a kick
		wr(8'h00, 32'h0);
		base = n_conv;
		wr(8'h28, 32'h8);
		repeat (60) @(posedge clk);
		chk("disabled", n_conv, base); // enable gates
		// always trigger keeps requesting
		wr(8'h14, 32'h0000_f210);
		base = n_conv;
		wr(8'h00, 32'h8);
		// two averaged entries into the one-deep queue
		wait_conv(base + 8);
		wr(8'h00, 32'h0);
		repeat (100) @(posedge clk);
		rc(8'h10, 32'h8, "always_ovf"); // repeated pushes
		// reset while idle restores defaults
		@(posedge clk);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk); // settle before access
		rc(8'h20, asq_pkg::PRIO_RST, "prio_rst2"); // default order
		rc(8'h30, 32'h0, "avg_rst2"); // averaging off
		summarize();
	end
endmodule
